// *** logic/astm_core.sv ***
// Purpose: subtract, divide step, xor and table moves on the accumulator
// Assumes: one instruction presented per INSTR_VALID_IN pulse while idle
// Notes:   memories sit outside; data word arrives with the instruction
//
// Behaviour
// - shifted subtract: shift data left, subtract, flag wrap, clamp if enabled
// - divide step flags wrap but never clamps
// - store copies data word to program address from accumulator low 12 bits
// - store reads data, then writes program memory, three cycles
// - push pc+1, load pc, write, update index, pop pc
// - store or fetch loses bottom stack entry
// - program stores to addresses 0..7 look like output port writes
// - xor changes accumulator low half only
`timescale 1ns/1ps
module astm_core
   import astm_pkg::*;
(
   input  wire logic        CLK_IN,          // 25 MHz processor clock
   input  wire logic        SYS_RST_IN,      // async reset, high
   input  wire logic        INSTR_VALID_IN,  // instruction strobe
   input  wire logic [15:0] INSTR_IN,        // instruction word
   input  wire logic [15:0] DATA_WORD_IN,    // addressed data memory word
   input  wire logic [11:0] PC_IN,           // current program counter
   input  wire logic        CLAMP_ENABLE_IN, // saturation mode
   input  wire logic [15:0] PM_RDATA_IN,     // program memory read data
   output logic      [31:0] ACC_OUT,         // running_total_reg
   output logic             SIGN_WRAP_FLAG_OUT, // overflow flag
   output logic             BUSY_OUT,        // table move in progress
   output logic      [11:0] PC_OUT,          // program counter during moves
   output logic             PC_LOAD_OUT,     // load PC_OUT into core pc
   output logic             PM_WE_OUT,       // program memory write strobe
   output logic             PM_RE_OUT,       // program memory read strobe
   output logic      [11:0] PM_ADDR_OUT,     // program memory address
   output logic      [15:0] PM_WDATA_OUT,    // program memory write data
   output logic             DM_WE_OUT,       // data memory write strobe
   output logic      [15:0] DM_WDATA_OUT,    // data memory write data
   output logic             INDEX_UPDATE_OUT,// update index_reg as coded
   output logic             PORT_ALIAS_OUT   // store aliases output port
);
   logic [31:0] acc_ff;
   logic        wrap_ff;
   astm_state_t state_ff;
   logic        busy_ff;
   logic [11:0] push_pc_ff;
   logic        is_store_ff;
   logic [15:0] hold_ff;
   logic        push_ff, pop_ff;
   logic [11:0] head;
   logic [11:0] pc_ff, pm_addr_ff;
   logic        pc_load_ff, pm_we_ff, pm_re_ff, dm_we_ff, idx_ff, alias_ff;
   logic [15:0] pm_wdata_ff, dm_wdata_ff;
   logic [31:0] nxt_acc;
   logic        nxt_wrap;

   // =====================================================================
   // signed subtract with wrap detect and optional clamp
   function automatic logic [32:0] sub_clamp(input logic [31:0] a, input logic [31:0] b,
                                             input logic clamp);
      logic [31:0] d;
      logic        ov;
      d  = a - b;
      ov = (a[31] != b[31]) && (d[31] != a[31]);
      if (ov && clamp) d = a[31] ? SAT_NEG : SAT_POS;
      return {ov, d};
   endfunction

   // =====================================================================
   // accumulator datapath for single-cycle instructions
   always_comb begin
      logic [32:0] r;
      logic [31:0] ext;
      logic [31:0] sh;
      r        = {1'b0, acc_ff};
      ext      = {{16{DATA_WORD_IN[15]}}, DATA_WORD_IN};
      sh       = ext << INSTR_IN[11:8];
      nxt_acc  = acc_ff;
      nxt_wrap = wrap_ff;
      if (INSTR_VALID_IN && state_ff == ST_IDLE) begin
         if (INSTR_IN[15:12] == OP_SUB_SHIFT) begin
            r = sub_clamp(acc_ff, sh, CLAMP_ENABLE_IN);
            nxt_acc = r[31:0];
            nxt_wrap = wrap_ff | r[32];
         end else if (INSTR_IN[15:8] == OP_UPPER_SUB) begin
            r = sub_clamp(acc_ff, {DATA_WORD_IN, 16'h0000}, CLAMP_ENABLE_IN);
            nxt_acc = r[31:0];
            nxt_wrap = wrap_ff | r[32];
         end else if (INSTR_IN[15:8] == OP_UNSIGNED_SUB) begin
            r = sub_clamp(acc_ff, {16'h0000, DATA_WORD_IN}, CLAMP_ENABLE_IN);
            nxt_acc = r[31:0];
            nxt_wrap = wrap_ff | r[32];
         end else if (INSTR_IN[15:8] == OP_DIV_STEP) begin
            r = sub_clamp(acc_ff, {1'b0, DATA_WORD_IN, 15'h0000}, 1'b0);
            nxt_wrap = wrap_ff | r[32];
            if (!r[31]) nxt_acc = {r[30:0], 1'b1};
            else        nxt_acc = {acc_ff[30:0], 1'b0};
         end else if (INSTR_IN[15:8] == OP_XOR_LOW) begin
            nxt_acc = {acc_ff[31:16], acc_ff[15:0] ^ DATA_WORD_IN};
         end
      end
   end

   // =====================================================================
   // accumulator and flag registers
   always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         acc_ff  <= 32'h00000000;
         wrap_ff <= 1'b0;
      end else begin
         acc_ff  <= nxt_acc;
         wrap_ff <= nxt_wrap;
      end
   end

   // =====================================================================
   // table move sequencer: read, move, pop over three cycles
   always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         state_ff    <= ST_IDLE;
         busy_ff     <= 1'b0;
         is_store_ff <= 1'b0;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               if (INSTR_VALID_IN && (INSTR_IN[15:8] == OP_WORD_STORE ||
                                      INSTR_IN[15:8] == OP_WORD_FETCH)) begin
                  state_ff    <= ST_READ;
                  busy_ff     <= 1'b1;
                  is_store_ff <= (INSTR_IN[15:8] == OP_WORD_STORE);
               end
            end
            ST_READ: begin
               state_ff <= ST_MOVE;
            end
            ST_MOVE: begin
               state_ff <= ST_POP;
            end
            ST_POP: begin
               state_ff <= ST_IDLE;
               busy_ff  <= 1'b0;
            end
            default: begin
               state_ff <= ST_IDLE;
               busy_ff  <= 1'b0;
            end
         endcase
      end
   end

   // =====================================================================
   // bus, stack and pc actions of the table moves
   always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         hold_ff <= 16'h0000; push_ff <= 1'b0; pop_ff <= 1'b0;
         pc_ff <= 12'h000; pc_load_ff <= 1'b0; pm_addr_ff <= 12'h000;
         pm_we_ff <= 1'b0; pm_re_ff <= 1'b0; pm_wdata_ff <= 16'h0000;
         dm_we_ff <= 1'b0; dm_wdata_ff <= 16'h0000; idx_ff <= 1'b0; alias_ff <= 1'b0;
         push_pc_ff <= 12'h000;
      end else begin
         push_ff <= 1'b0; pop_ff <= 1'b0; pc_load_ff <= 1'b0;
         pm_we_ff <= 1'b0; pm_re_ff <= 1'b0; dm_we_ff <= 1'b0;
         idx_ff <= 1'b0; alias_ff <= 1'b0;
         unique case (state_ff)
            ST_IDLE: begin
               if (INSTR_VALID_IN && (INSTR_IN[15:8] == OP_WORD_STORE ||
                                      INSTR_IN[15:8] == OP_WORD_FETCH)) begin
                  hold_ff    <= DATA_WORD_IN;
                  push_pc_ff <= PC_IN + 12'h001;
                  push_ff    <= 1'b1;
                  pc_ff      <= acc_ff[PM_ADDR_W-1:0];
                  pc_load_ff <= 1'b1;
                  pm_addr_ff <= acc_ff[PM_ADDR_W-1:0];
               end
            end
            ST_READ: begin
               if (is_store_ff) begin
                  pm_we_ff    <= 1'b1;
                  pm_wdata_ff <= hold_ff;
                  alias_ff    <= (pm_addr_ff <= OUT_PORT_TOP);
               end else begin
                  pm_re_ff <= 1'b1;
               end
            end
            ST_MOVE: begin
               idx_ff <= 1'b1;
               pop_ff <= 1'b1;
               if (!is_store_ff) begin
                  dm_we_ff    <= 1'b1;
                  dm_wdata_ff <= PM_RDATA_IN;
               end
            end
            ST_POP: begin
               pc_ff      <= head;
               pc_load_ff <= 1'b1;
            end
            default: ;
         endcase
      end
   end

   astm_stack u_stack (
      .clk_in   (CLK_IN),
      .rst_in   (SYS_RST_IN),
      .push_in  (push_ff),
      .pop_in   (pop_ff),
      .data_in  (push_pc_ff),
      .head_out (head)
   );

   assign ACC_OUT            = acc_ff;
   assign SIGN_WRAP_FLAG_OUT = wrap_ff;
   assign BUSY_OUT           = busy_ff;
   assign PC_OUT             = pc_ff;
   assign PC_LOAD_OUT        = pc_load_ff;
   assign PM_WE_OUT          = pm_we_ff;
   assign PM_RE_OUT          = pm_re_ff;
   assign PM_ADDR_OUT        = pm_addr_ff;
   assign PM_WDATA_OUT       = pm_wdata_ff;
   assign DM_WE_OUT          = dm_we_ff;
   assign DM_WDATA_OUT       = dm_wdata_ff;
   assign INDEX_UPDATE_OUT   = idx_ff;
   assign PORT_ALIAS_OUT     = alias_ff;
endmodule // astm_core

// *** logic/astm_pkg.sv ***
// Purpose: shared constants for the accumulator subtract and table move unit
// Assumes: one clock, asynchronous active-high reset
// Notes:   opcode codes are taken from the top bits of the instruction word
package astm_pkg;
   // =====================================================================
   // opcodes (instruction bits 15:8 unless noted)
   localparam logic [3:0] OP_SUB_SHIFT   = 4'h1;      // bits 15:12, shift in 11:8
   localparam logic [7:0] OP_DIV_STEP    = 8'h64;
   localparam logic [7:0] OP_UPPER_SUB   = 8'h62;
   localparam logic [7:0] OP_UNSIGNED_SUB = 8'h63;
   localparam logic [7:0] OP_WORD_FETCH  = 8'h67;
   localparam logic [7:0] OP_WORD_STORE  = 8'h7D;
   localparam logic [7:0] OP_XOR_LOW     = 8'h78;
   // =====================================================================
   // widths and limits
   localparam int         ACC_W          = 32;
   localparam int         PM_ADDR_W      = 12;
   localparam int         STACK_DEPTH    = 4;
   localparam int         HALF_SHIFT     = 16;
   localparam logic [31:0] SAT_POS       = 32'h7FFFFFFF;
   localparam logic [31:0] SAT_NEG       = 32'h80000000;
   localparam logic [11:0] OUT_PORT_TOP  = 12'h007;   // stores at or below alias port writes
   localparam logic [1:0] TABLE_LAST     = 2'h2;      // third machine cycle
   // =====================================================================
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_READ  = 4'b0010,
      ST_MOVE  = 4'b0100,
      ST_POP   = 4'b1000
   } astm_state_t;
endpackage

// *** logic/astm_stack.sv ***
// Purpose: four-deep hardware return stack with registered head
// Assumes: push and pop never coincide
// Notes:   a push shifts the bottom entry out and loses it
`timescale 1ns/1ps
module astm_stack
   import astm_pkg::*;
(
   input  wire logic        clk_in,    // processor clock
   input  wire logic        rst_in,    // async reset, high
   input  wire logic        push_in,   // push strobe
   input  wire logic        pop_in,    // pop strobe
   input  wire logic [11:0] data_in,   // value to push
   output logic      [11:0] head_out   // registered top entry
);
   logic [11:0] mem_ff [STACK_DEPTH];

   // =====================================================================
   // shift register stack; pop duplicates the bottom entry
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < STACK_DEPTH; i++) mem_ff[i] <= 12'h000;
      end else if (push_in) begin
         mem_ff[0] <= data_in;
         for (int i = 1; i < STACK_DEPTH; i++) mem_ff[i] <= mem_ff[i-1];
      end else if (pop_in) begin
         for (int i = 0; i < STACK_DEPTH-1; i++) mem_ff[i] <= mem_ff[i+1];
      end
   end

   assign head_out = mem_ff[0];
endmodule // astm_stack

// *** tb/astm_assertions.sv ***
// Purpose: port checks for the subtract and table move unit
// Assumes: one clock, reset high
// Notes:   accumulator results show one cycle after the taking edge
`timescale 1ns/1ps
module astm_checker
   import astm_pkg::*;
(
   input wire logic        CLK_IN,           // clock
   input wire logic        SYS_RST_IN,       // reset
   input wire logic        INSTR_VALID_IN,   // strobe
   input wire logic [15:0] INSTR_IN,         // instruction
   input wire logic [15:0] DATA_WORD_IN,     // data word
   input wire logic [11:0] PC_IN,            // pc
   input wire logic        CLAMP_ENABLE_IN,  // clamp
   input wire logic [31:0] ACC_OUT,          // total
   input wire logic        BUSY_OUT,         // busy
   input wire logic [11:0] PC_OUT,           // pc load value
   input wire logic        PC_LOAD_OUT,      // pc load
   input wire logic        PM_WE_OUT,        // pm write
   input wire logic        PM_RE_OUT,        // pm read
   input wire logic [11:0] PM_ADDR_OUT,      // pm address
   input wire logic [15:0] PM_WDATA_OUT,     // pm data
   input wire logic        DM_WE_OUT,        // dm write
   input wire logic        INDEX_UPDATE_OUT, // index update
   input wire logic        PORT_ALIAS_OUT    // alias
);
   // =====================================================================
   // expected results worked out from the current inputs
   wire logic        take  = INSTR_VALID_IN && !BUSY_OUT;
   wire logic [7:0]  op    = INSTR_IN[15:8];
   wire logic [11:0] acc_lo = ACC_OUT[11:0];
   wire logic [31:0] dsx   = {{16{DATA_WORD_IN[15]}}, DATA_WORD_IN};
   wire logic [31:0] sub_v = ACC_OUT - (dsx << INSTR_IN[11:8]);
   wire logic [31:0] up_v  = ACC_OUT - {DATA_WORD_IN, 16'h0000};
   wire logic [31:0] xor_v = {ACC_OUT[31:16], ACC_OUT[15:0] ^ DATA_WORD_IN};
   wire logic [31:0] dif   = ACC_OUT - ({16'h0000, DATA_WORD_IN} << 15);
   wire logic [31:0] div_v = dif[31] ? {ACC_OUT[30:0], 1'h0} : {dif[30:0], 1'h1};
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (SYS_RST_IN);
   // =====================================================================
   // properties
   property p_busy_len;
      $rose(BUSY_OUT) |-> BUSY_OUT[*3] ##1 !BUSY_OUT;
   endproperty
   property p_store;
      take && op == OP_WORD_STORE |=> PC_LOAD_OUT && PC_OUT == $past(acc_lo) ##1
         PM_WE_OUT && PM_ADDR_OUT == $past(acc_lo, 2) && PM_WDATA_OUT == $past(DATA_WORD_IN, 2);
   endproperty
   property p_ret;
      take && (op == OP_WORD_STORE || op == OP_WORD_FETCH) |->
         ##4 PC_LOAD_OUT && PC_OUT == $past(PC_IN, 4) + 12'h001;
   endproperty
   property p_alias;
      PM_WE_OUT |-> PORT_ALIAS_OUT == (PM_ADDR_OUT <= OUT_PORT_TOP);
   endproperty
   property p_fetch;
      take && op == OP_WORD_FETCH |-> ##2 PM_RE_OUT && PM_ADDR_OUT == $past(acc_lo, 2)
         ##1 DM_WE_OUT && INDEX_UPDATE_OUT;
   endproperty
   property p_xor;
      take && op == OP_XOR_LOW |=> ACC_OUT == $past(xor_v);
   endproperty
   property p_upper;
      take && op == OP_UPPER_SUB && !CLAMP_ENABLE_IN |=> ACC_OUT == $past(up_v);
   endproperty
   property p_div;
      take && op == OP_DIV_STEP |=> ACC_OUT == $past(div_v);
   endproperty
   property p_sub;
      take && INSTR_IN[15:12] == OP_SUB_SHIFT && !CLAMP_ENABLE_IN |=> ACC_OUT == $past(sub_v);
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("move length wrong");
   a_store: assert property (p_store) else $error("store sequence wrong");
   a_ret: assert property (p_ret) else $error("return pc wrong");
   a_alias: assert property (p_alias) else $error("alias wrong");
   a_fetch: assert property (p_fetch) else $error("fetch sequence wrong");
   a_xor: assert property (p_xor) else $error("xor result wrong");
   a_upper: assert property (p_upper) else $error("upper subtract wrong");
   a_div: assert property (p_div) else $error("divide step wrong");
   a_sub: assert property (p_sub) else $error("shifted subtract wrong");
   c_store: cover property (take && op == OP_WORD_STORE);
   c_fetch: cover property (take && op == OP_WORD_FETCH);
   c_alias: cover property (PORT_ALIAS_OUT);
endmodule // astm_checker

bind astm_core astm_checker i_astm_checker (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
   .INSTR_VALID_IN(INSTR_VALID_IN), .INSTR_IN(INSTR_IN), .DATA_WORD_IN(DATA_WORD_IN),
   .PC_IN(PC_IN), .CLAMP_ENABLE_IN(CLAMP_ENABLE_IN), .ACC_OUT(ACC_OUT), .BUSY_OUT(BUSY_OUT),
   .PC_OUT(PC_OUT), .PC_LOAD_OUT(PC_LOAD_OUT), .PM_WE_OUT(PM_WE_OUT), .PM_RE_OUT(PM_RE_OUT),
   .PM_ADDR_OUT(PM_ADDR_OUT), .PM_WDATA_OUT(PM_WDATA_OUT), .DM_WE_OUT(DM_WE_OUT),
   .INDEX_UPDATE_OUT(INDEX_UPDATE_OUT), .PORT_ALIAS_OUT(PORT_ALIAS_OUT));

// *** tb/astm_mem_model.sv ***
// Purpose: program memory on the external bus
// Assumes: read data wanted while strobed or the cycle after
// Notes:   outside that window the bus shows junk
`timescale 1ns/1ps
module astm_mem_model (
   input  wire logic        clk_in,    // clock
   input  wire logic        we_in,     // write strobe
   input  wire logic        re_in,     // read strobe
   input  wire logic [11:0] addr_in,   // address
   input  wire logic [15:0] wdata_in,  // write data
   output logic      [15:0] rdata_out  // read data
);
   logic [15:0] mem [0:4095];
   logic        re_ff;
   logic [15:0] last_ff;
   // writes land here, port addresses 0..7 included
   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem[addr_in] <= wdata_in;
      end
      re_ff   <= re_in;
      last_ff <= rdata_out;
   end
   // inverted last value once the read window closes
   always_comb begin
      rdata_out = (re_in || re_ff) ? mem[addr_in] : ~last_ff;
   end
endmodule // astm_mem_model

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the subtract and table move unit
// Assumes: pc starts at 100h and follows the loads of the moves
// Notes:   accumulator built from zero with xor and subtracts
`timescale 1ns/1ps
module testbench;
   import astm_pkg::*;
   logic        clk, rst, vld, clamp, wrap, busy, pcl, pwe, pre, dwe, idx, alias_p;
   logic [15:0] instr, dword, rdata, pwd, dwd;
   logic [11:0] pc, pco, paddr;
   logic [31:0] acc;
   int          n_errors, comparisons;
   // a word this block does not decode; stands for one that leaves the total alone
   localparam logic [15:0] NO_ACC_INSTR = 16'hFF00;
   astm_core i_astm_core (.CLK_IN(clk), .SYS_RST_IN(rst), .INSTR_VALID_IN(vld),
      .INSTR_IN(instr), .DATA_WORD_IN(dword), .PC_IN(pc), .CLAMP_ENABLE_IN(clamp),
      .PM_RDATA_IN(rdata), .ACC_OUT(acc), .SIGN_WRAP_FLAG_OUT(wrap), .BUSY_OUT(busy),
      .PC_OUT(pco), .PC_LOAD_OUT(pcl), .PM_WE_OUT(pwe), .PM_RE_OUT(pre),
      .PM_ADDR_OUT(paddr), .PM_WDATA_OUT(pwd), .DM_WE_OUT(dwe), .DM_WDATA_OUT(dwd),
      .INDEX_UPDATE_OUT(idx), .PORT_ALIAS_OUT(alias_p));
   astm_mem_model i_astm_mem_model (.clk_in(clk), .we_in(pwe), .re_in(pre),
      .addr_in(paddr), .wdata_in(pwd), .rdata_out(rdata));
   // core program counter: follows the loads that the moves ask for
   always @(posedge clk) begin
      if (rst) begin
         pc <= 12'h100;
      end else if (pcl === 1'h1) begin
         pc <= pco;
      end
   end
   // =====================================================================
   // clock
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, exp, input string msg);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // one instruction, result visible after the taking edge
   task automatic issue(input logic [15:0] ins, d);
      @(posedge clk);
      vld <= 1'h1;
      instr <= ins;
      dword <= d;
      @(posedge clk);
      vld <= 1'h0;
      #1;
   endtask
   // =====================================================================
   // scenarios
   task automatic t_alu();
      issue({OP_XOR_LOW, 8'h00}, 16'h1234);
      check(acc, 32'h00001234, "xor");
      issue({OP_SUB_SHIFT, 4'h4, 8'h00}, 16'h0012);
      check(acc, 32'h00001114, "shifted subtract");
      issue({OP_UPPER_SUB, 8'h00}, 16'h0001);
      check(acc, 32'hFFFF1114, "upper subtract");
      issue({OP_UNSIGNED_SUB, 8'h00}, 16'h8000);
      check(acc, 32'hFFFE9114, "unsigned subtract");
      check({31'h0, wrap}, 32'h0, "early flag");
   endtask
   task automatic t_div();
      clamp <= 1'h1;
      issue({OP_UPPER_SUB, 8'h00}, 16'h7FFF);
      check(acc, SAT_NEG, "clamped");
      check({31'h0, wrap}, 32'h1, "flag");
      issue({OP_DIV_STEP, 8'h00}, 16'h0001);
      check(acc, 32'hFFFF0001, "divide step not clamped");
      issue(NO_ACC_INSTR, 16'h0000);
      issue({OP_UPPER_SUB, 8'h00}, 16'hFFFF);
      issue({OP_XOR_LOW, 8'h00}, 16'h0006);
      // dividend 7 keeps its leading zeros, divisor 2 is positive
      for (int i = 0; i < 16; i++) begin
         issue({OP_DIV_STEP, 8'h00}, 16'h0002);
         issue(NO_ACC_INSTR, 16'h0000);
      end
      check(acc, 32'h00010003, "seven over two");
   endtask
   task automatic t_move(input logic [7:0] op, input logic [15:0] d, exp_d, input logic al);
      logic [31:0] acc0;
      logic [11:0] pc0;
      logic        seen_al;
      int          nbusy;
      int          nload;
      int          nidx;
      acc0 = acc;
      pc0 = pc;
      seen_al = 1'h0;
      nbusy = 0;
      nload = 0;
      nidx = 0;
      @(posedge clk);
      vld <= 1'h1;
      instr <= {op, 8'h00};
      dword <= d;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         vld <= (i == 1);
         instr <= {OP_XOR_LOW, 8'h00};
         #1;
         nbusy += (busy === 1'h1);
         nidx += (idx === 1'h1);
         if (pcl === 1'h1) begin
            nload++;
            check({20'h0, pco}, {20'h0, (nload == 1) ? acc0[11:0] : pc0 + 12'h001}, "pc");
         end
         if (pwe === 1'h1) begin
            check({paddr, pwd}, {acc0[11:0], d}, "store");
            seen_al = alias_p;
         end
         if (dwe === 1'h1) begin
            check({16'h0, dwd}, {16'h0, exp_d}, "fetched word");
         end
      end
      if (busy !== 1'h0) begin
         n_errors++;
         tally_and_finish();
      end
      check(32'(nbusy), 32'h3, "move length");
      check(32'(nidx), 32'h1, "index update");
      check({31'h0, seen_al}, {31'h0, al}, "alias");
      check(acc, acc0, "request while busy");
   endtask
   // =====================================================================
   // main sequence
   initial begin
      rst = 1'h1;
      vld = 1'h0;
      clamp = 1'h0;
      instr = 16'h0000;
      dword = 16'h0000;
      n_errors = 0;
      comparisons = 0;
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      t_alu();
      t_div();
      t_move(OP_WORD_STORE, 16'hABCD, 16'h0000, 1'h1);
      issue({OP_XOR_LOW, 8'h00}, 16'h0008);
      t_move(OP_WORD_STORE, 16'h5A5A, 16'h0000, 1'h0);
      t_move(OP_WORD_FETCH, 16'h00F0, 16'h5A5A, 1'h0);
      tally_and_finish();
   end
endmodule // testbench
